/* File: rtl/light_sensor_read_and_conversion.v */
// i2c register slave with ambient light conversion sequencer
`timescale 1ns/1ps
`include "als_regs.vh"
// Behaviour
// R1 - reserved infrared register left unused by host
// R2 - idle without request: standby, only serial active
// R3 - emitter sink off in standby
// R4 - pointer write without data, then read
// R5 - stop-start or repeated start both accepted
// R6 - pointer advances by one after each read
// R7 - host writes write address then pointer
// R8 - read returns high byte then low byte
// R9 - standard mode uses fixed 100 ms frame
// R10 - single conversion lasts about 300 us
// R11 - averaging count selectable up to 128
// R12 - result is mean of conversions
// R13 - standard mode result only after frame
// R14 - continuous mode runs conversions back to back
module light_sensor_read_and_conversion #(
	parameter FRAME_CYCLES = `FRAME_CYC,
	parameter CONV_CYCLES  = `CONV_CYC
) (
	// clock and reset
	input  wire        clk,
	input  wire        resetn,
	// two-wire serial pins
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_oe_ff,
	// light front end
	input  wire [15:0] adc_sample,
	output reg         adc_run_ff,
	output reg         standby_ff,
	output reg         ired_sink_en_ff
);
	localparam S_IDLE = 3'h0, S_ADDR = 3'h1, S_ACK = 3'h2, S_RX = 3'h3,
		S_TX = 3'h4, S_RACK = 3'h5, S_WAIT = 3'h6;
	localparam M_IDLE = 2'h0, M_CONV = 2'h1, M_FILL = 2'h2;
	reg        scl_d_ff, sda_d_ff;
	reg [2:0]  st_ff;
	reg [3:0]  bit_ff;
	reg [7:0]  sh_ff;
	reg        rd_ff, first_ff, addr_ok_ff;
	reg [7:0]  ptr_ff;
	reg [7:0]  cmd_ff, param_ff;
	reg [15:0] result_ff;
	reg [1:0]  m_ff;
	reg [31:0] frame_cnt_ff, conv_cnt_ff;
	reg [7:0]  n_ff;
	reg [23:0] acc_ff;
	reg        pend_ff;
	wire scl_rise = scl_in & ~scl_d_ff;
	wire scl_fall = ~scl_in & scl_d_ff;
	wire start_c  = scl_in & scl_d_ff & sda_d_ff & ~sda_in;
	wire stop_c   = scl_in & scl_d_ff & ~sda_d_ff & sda_in;
	wire cont     = param_ff[`PARAM_CONT_BIT];
	function [7:0] avg_count;
		input [2:0] code;
		avg_count = 8'h01 << code;
	endfunction
	function [7:0] reg_read;
		input [7:0] a;
		if (a == `REG_ALS_CMD)
			reg_read = cmd_ff;
		else if (a == `REG_ALS_PARAM)
			reg_read = param_ff;
		else if (a == `REG_ALS_HIGH)
			reg_read = result_ff[15:8];
		else if (a == `REG_ALS_LOW)
			reg_read = result_ff[7:0];
		else
			reg_read = 8'h00; // reserved and unmapped locations read zero
	endfunction
	wire [7:0] avg_n = avg_count(param_ff[2:0]); // R11
	wire [7:0]  rd_byte = reg_read(ptr_ff);
	// sum of 2^n samples shifted by n; the low bits of the sum are dropped on purpose
	wire [23:0] mean = acc_ff >> param_ff[2:0]; // R12
	// i2c slave
	always @(posedge clk) begin
		if (!resetn) begin
			scl_d_ff   <= 1'b1;
			sda_d_ff   <= 1'b1;
			st_ff      <= S_IDLE;
			bit_ff     <= 4'h0;
			sh_ff      <= 8'h00;
			rd_ff      <= 1'b0;
			first_ff   <= 1'b0;
			addr_ok_ff <= 1'b0;
			ptr_ff     <= 8'h00;
			sda_oe_ff  <= 1'b0;
		end else begin
			scl_d_ff <= scl_in;
			sda_d_ff <= sda_in;
			if (start_c) begin // R5
				st_ff     <= S_ADDR;
				bit_ff    <= 4'h0;
				sda_oe_ff <= 1'b0;
			end else if (stop_c) begin // R5
				st_ff     <= S_IDLE;
				sda_oe_ff <= 1'b0;
			end else begin
				case (st_ff)
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						sh_ff  <= {sh_ff[6:0], sda_in};
						bit_ff <= bit_ff + 4'h1;
					end
					if (scl_fall && bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						if (st_ff == S_ADDR) begin
							addr_ok_ff <= (sh_ff[7:1] == `DEV_ADDR);
							rd_ff      <= sh_ff[0];
							first_ff   <= 1'b1;
							if (sh_ff[7:1] == `DEV_ADDR) begin
								sda_oe_ff <= 1'b1;
								st_ff     <= S_ACK;
							end else
								st_ff <= S_WAIT;
						end else begin
							sda_oe_ff <= 1'b1;
							st_ff     <= S_ACK;
							if (first_ff) begin
								ptr_ff   <= sh_ff; // R4 R7
								first_ff <= 1'b0;
							end
							// data bytes after the pointer are acked; wr_byte writes them to the command or parameter register
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						if (rd_ff && st_ff == S_ACK && addr_ok_ff) begin
							sh_ff     <= rd_byte; // R8
							sda_oe_ff <= ~rd_byte[7];
							ptr_ff    <= ptr_ff + 8'h01; // R6
							bit_ff    <= 4'h1;
							st_ff     <= S_TX;
						end else begin
							sda_oe_ff <= 1'b0;
							st_ff     <= S_RX;
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (bit_ff == 4'h8) begin
							sda_oe_ff <= 1'b0;
							st_ff     <= S_RACK;
						end else begin
							sda_oe_ff <= ~sh_ff[3'd7 - bit_ff[2:0]];
							bit_ff    <= bit_ff + 4'h1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						if (sda_in)
							st_ff <= S_WAIT; // host nack ends the read
						else
							st_ff <= S_ACK;
					end
				end
				default: ;
				endcase
			end
		end
	end
	// register writes are decoded on the byte after the pointer
	wire wr_byte = (st_ff == S_RX) && scl_fall && bit_ff == 4'h8 && !first_ff && addr_ok_ff;
	// conversion sequencer
	always @(posedge clk) begin
		if (!resetn) begin
			cmd_ff          <= `CMD_RESET;
			param_ff        <= `PARAM_RESET;
			result_ff       <= 16'h0000;
			m_ff            <= M_IDLE;
			frame_cnt_ff    <= 32'h0;
			conv_cnt_ff     <= 32'h0;
			n_ff            <= 8'h00;
			acc_ff          <= 24'h0;
			pend_ff         <= 1'b0;
			adc_run_ff      <= 1'b0;
			standby_ff      <= 1'b1;
			ired_sink_en_ff <= 1'b0;
		end else begin
			ired_sink_en_ff <= 1'b0; // R3
			standby_ff      <= (m_ff == M_IDLE) && !cmd_ff[`CMD_ALS_OD_BIT]; // R2
			if (wr_byte && ptr_ff == `REG_ALS_CMD)
				cmd_ff <= {1'b0, sh_ff[6:0] & 7'h10};
			else if (wr_byte && ptr_ff == `REG_ALS_PARAM)
				param_ff <= sh_ff;
			case (m_ff)
			M_IDLE: begin
				if (cmd_ff[`CMD_ALS_OD_BIT]) begin
					m_ff         <= M_CONV;
					frame_cnt_ff <= 32'h0;
					conv_cnt_ff  <= 32'h0;
					n_ff         <= 8'h00;
					acc_ff       <= 24'h0;
					adc_run_ff   <= 1'b1;
					cmd_ff[`CMD_ALS_RDY_BIT] <= 1'b0;
				end
			end
			M_CONV: begin
				frame_cnt_ff <= frame_cnt_ff + 32'h1;
				if (conv_cnt_ff == CONV_CYCLES - 1) begin // R10
					conv_cnt_ff <= 32'h0;
					acc_ff      <= acc_ff + {8'h00, adc_sample};
					n_ff        <= n_ff + 8'h01;
					if (n_ff + 8'h01 == avg_n) begin
						adc_run_ff <= 1'b0;
						m_ff       <= M_FILL;
						pend_ff    <= 1'b1;
					end else
						adc_run_ff <= 1'b1; // R14
				end else
					conv_cnt_ff <= conv_cnt_ff + 32'h1;
				// both modes convert back to back; standard mode then idles out the frame
			end
			M_FILL: begin
				frame_cnt_ff <= frame_cnt_ff + 32'h1;
				if (cont || frame_cnt_ff >= FRAME_CYCLES - 1) begin // R9 R13
					result_ff <= mean[15:0]; // R12
					pend_ff   <= 1'b0;
					cmd_ff[`CMD_ALS_RDY_BIT] <= 1'b1;
					cmd_ff[`CMD_ALS_OD_BIT]  <= 1'b0;
					m_ff      <= M_IDLE;
				end
			end
			default: m_ff <= M_IDLE;
			endcase
		end
	end
endmodule // light_sensor_read_and_conversion

/* File: rtl/als_regs.vh */
// register offsets, field positions and timing constants for the light sensor readout
`ifndef ALS_REGS_VH
`define ALS_REGS_VH
`define REG_ALS_CMD      8'h80
`define REG_ALS_PARAM    8'h84
`define REG_ALS_HIGH     8'h85
`define REG_ALS_LOW      8'h86
`define REG_AMB_IR       8'h90
`define CMD_ALS_OD_BIT   4
`define CMD_ALS_RDY_BIT  6
`define PARAM_CONT_BIT   7
`define PARAM_AVG_LSB    0
`define DEV_ADDR         7'h13
`define FRAME_US         100000
`define CONV_US          300
`define CLK_MHZ          250
`define FRAME_CYC        (`FRAME_US * `CLK_MHZ)
`define CONV_CYC         (`CONV_US * `CLK_MHZ)
`define CMD_RESET        8'h00
`define PARAM_RESET      8'h0D
`endif

/* File: bench/light_host.sv */
// two-wire host model that reads and writes the sensor registers
`timescale 1ns/1ps
`include "als_regs.vh"
module light_host (
	// clock
	input  wire  clk,
	// bus, released lines read high through the pull-up
	input  wire  sda_in,
	output logic scl,
	output logic sda,
	output logic nak
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		nak = 1'b0;
	end
	// six cycles a phase leaves the slave room for its synchroniser
	task automatic w;
		repeat (6) @(posedge clk);
	endtask
	task automatic bt(input logic b, output logic r);
		sda <= b;
		w;
		scl <= 1'b1;
		w;
		r = sda_in;
		scl <= 1'b0;
		w;
	endtask
	// from idle or from a low clock, so it also serves as repeated start
	task automatic st;
		sda <= 1'b1;
		w;
		scl <= 1'b1;
		w;
		sda <= 1'b0;
		w;
		scl <= 1'b0;
		w;
	endtask
	task automatic sp;
		sda <= 1'b0;
		w;
		scl <= 1'b1;
		w;
		sda <= 1'b1;
		w;
	endtask
	task automatic wb(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bt(d[i], r);
		bt(1'b1, r);
		nak <= nak | r;
	endtask
	task automatic rb(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bt(1'b1, d[i]);
		bt(last, r);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		st;
		wb({`DEV_ADDR, 1'b0});
		wb(p);
		wb(d);
		sp;
	endtask
	// never aimed at the reserved infrared place
	task automatic rd2(input logic [7:0] p, input logic rs, output logic [15:0] v);
		st;
		wb({`DEV_ADDR, 1'b0});
		wb(p);
		if (!rs)
			sp;
		st;
		wb({`DEV_ADDR, 1'b1});
		rb(1'b0, v[15:8]);
		rb(1'b1, v[7:0]);
		sp;
	endtask
endmodule // light_host

/* File: bench/light_checker.sv */
// port assertions for the light sensor readout
`timescale 1ns/1ps
module light_checker #(
	parameter CONV_CYCLES = 10
) (
	input wire        clk,
	input wire        resetn,
	input wire        scl_in,
	input wire        sda_in,
	input wire        sda_oe_ff,
	input wire [15:0] adc_sample,
	input wire        adc_run_ff,
	input wire        standby_ff,
	input wire        ired_sink_en_ff
);
	logic [31:0] run_len_ff;
	always_ff @(posedge clk)
		run_len_ff <= (resetn && adc_run_ff) ? run_len_ff + 32'h00000001 : 32'h00000000;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_sink_off: assert property (standby_ff |-> !ired_sink_en_ff)
		else $error("emitter sink on in standby");
	a_run_awake: assert property (adc_run_ff |-> !standby_ff)
		else $error("conversion during standby");
	a_conv_whole: assert property ($fell(adc_run_ff) |-> run_len_ff % CONV_CYCLES == 0 && run_len_ff <= 128 * CONV_CYCLES)
		else $error("conversion run length");
	a_reset_idle: assert property ($rose(resetn) |-> standby_ff && !sda_oe_ff && !adc_run_ff)
		else $error("outputs after reset");
	a_oe_scl_low: assert property ($changed(sda_oe_ff) |-> !scl_in)
		else $error("data moved with clock high");
	a_start_free: assert property ($fell(sda_in) && scl_in |-> !sda_oe_ff)
		else $error("slave drove a start");
	a_wake_run: assert property ($fell(standby_ff) |-> ##[0:8] adc_run_ff)
		else $error("left standby without converting");
	a_sink_never: assert property (!ired_sink_en_ff)
		else $error("emitter sink enabled");
	c_conv: cover property ($fell(adc_run_ff));
	c_drive: cover property ($rose(sda_oe_ff));
	c_sleep: cover property ($rose(standby_ff));
endmodule // light_checker
bind light_sensor_read_and_conversion light_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
	.clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_ff(sda_oe_ff),
	.adc_sample(adc_sample), .adc_run_ff(adc_run_ff), .standby_ff(standby_ff),
	.ired_sink_en_ff(ired_sink_en_ff));

/* File: bench/tb_top.sv */
// self-checking bench for the light sensor readout
`timescale 1ns/1ps
`include "als_regs.vh"
module tb_top;
	localparam CONV = 4;
	localparam FRAME = 3000;
	logic clk = 1'b0, resetn = 1'b0, scl, sda, nak, sda_oe_ff, adc_run_ff, standby_ff, sink, run_q;
	logic [15:0] adc_sample = 16'h0000, v, prev, got, lfsr = 16'h0037, runs, rises;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	wire sda_in = sda & ~sda_oe_ff;
	light_sensor_read_and_conversion #(.FRAME_CYCLES(FRAME), .CONV_CYCLES(CONV)) dut (
		.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_in), .sda_oe_ff(sda_oe_ff),
		.adc_sample(adc_sample), .adc_run_ff(adc_run_ff), .standby_ff(standby_ff),
		.ired_sink_en_ff(sink));
	light_host h (.clk(clk), .sda_in(sda_in), .scl(scl), .sda(sda), .nak(nak));
	initial forever #2 clk = ~clk;
	function logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// run counts feed the averaging and back-to-back checks
	always @(posedge clk) begin
		cyc++;
		run_q <= adc_run_ff;
		if (adc_run_ff)
			runs = runs + 16'h0001;
		if (adc_run_ff && !run_q)
			rises = rises + 16'h0001;
		if (cyc > 90000) begin
			error_cnt++;
			test_done;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk(standby_ff, 16'h0001);
		// odd counts use the fixed frame, even ones run continuously
		for (int n = 0; n < 8; n++) begin
			lfsr = nx(lfsr);
			v = lfsr;
			h.wr(`REG_ALS_PARAM, {~n[0], 4'h0, n[2:0]});
			adc_sample <= v;
			runs = 16'h0000;
			rises = 16'h0000;
			h.wr(`REG_ALS_CMD, 8'h10);
			for (int i = 0; i < 2000 && runs < (CONV << n); i++)
				@(posedge clk);
			repeat (2 * CONV) @(posedge clk);
			h.rd2(`REG_ALS_HIGH, n[1], got);
			chk(got, n[0] ? prev : v);
			repeat (FRAME) @(posedge clk);
			h.rd2(`REG_ALS_HIGH, ~n[1], got);
			chk(got, v);
			chk(runs, 16'(CONV << n));
			if (!n[0])
				chk(rises, 16'h0001);
			chk(standby_ff, 16'h0001);
			prev = v;
			$display("test %0d done", n);
		end
		// ready set and request cleared; pointer then walks into an unmapped place
		h.rd2(`REG_ALS_CMD, 1'b0, got);
		chk(got, 16'h4000);
		h.rd2(`REG_ALS_PARAM, 1'b1, got);
		chk(got, {8'h07, v[15:8]});
		chk(sink, 16'h0000);
		$display("test readback done");
		chk(nak, 16'h0000);
		test_done;
	end
endmodule // tb_top
